// File: hdl/ppp_cfg.svh
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
// ****************************************************************
// action select codes sampled at the load strobe
// ****************************************************************
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3
// byte select pair during address loading
`define BSEL_LO 2'h0
`define BSEL_HI 2'h1
`define BSEL_EXT 2'h2
// command bytes
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EE 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EE 8'h03
// memory geometry
`define FLASH_ADDR_W 14
`define FLASH_WORD_W 7
`define EE_ADDR_W 10
`define EE_BYTE_W 3
// reset values and entry timing
`define RESET_BYTE 8'h00
`define ENTRY_PINS_IDLE 4'h0
`define MCLK_PERIOD_NS 25
`define ENTRY_QUIET_NS 100
`define ENTRY_QUIET_CYC ((`ENTRY_QUIET_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// File: hdl/ppp_pkg.sv
package ppp_pkg;
    // operations handed to the nonvolatile macro
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LATCH_FLASH = 4'h1,
        OP_LATCH_EE = 4'h2,
        OP_PROG_FLASH = 4'h3,
        OP_PROG_EE = 4'h4,
        OP_WR_FUSE = 4'h5,
        OP_WR_LOCK = 4'h6,
        OP_ERASE_FLASH = 4'h7,
        OP_ERASE_EE = 4'h8,
        OP_ERASE_LOCK = 4'h9,
        OP_END = 4'ha
    } nvm_op_type;
    typedef struct packed {
        nvm_op_type op;
        logic [15:0] addr;
        logic [15:0] data;
        logic [1:0] bsel;
    } nvm_req_type;
    typedef struct packed {
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [1:0] bsel;
    } rd_req_type;
    typedef struct packed {
        logic load_strobe;
        logic page_latch_strobe;
        logic action_select_hi;
        logic action_select_lo;
        logic byte_select_hi;
        logic byte_select_lo;
        logic wr_n;
        logic oe_n;
    } ctl_pins_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_BUSY = 3'b100
    } state_type;
endpackage : ppp_pkg

// File: hdl/req_fifo.sv
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] slot_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;
    // full and empty come straight from the count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = slot_r[rd_idx_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage written at the write index only
    always_ff @(posedge mclk) begin
        if (push) begin
            slot_r[wr_idx_r] <= in_data;
        end
    end
    // pointers wrap at the depth, count tracks occupancy
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_idx_r <= (wr_idx_r == AW'(DEPTH - 1)) ? '0 : wr_idx_r + 1'b1;
            end
            if (pop) begin
                rd_idx_r <= (rd_idx_r == AW'(DEPTH - 1)) ? '0 : rd_idx_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : req_fifo

// File: hdl/prog_entry.sv
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module prog_entry (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // entry inputs
    input wire logic hv_present,
    input wire logic [3:0] entry_pins,
    // result
    output logic prog_mode
);
    logic hv_prev_r;
    logic watch_r;
    logic mode_r;
    logic fail_r;
    logic [3:0] quiet_cnt_r;
    logic hv_rise;
    assign hv_rise = hv_present && !hv_prev_r;
    assign prog_mode = mode_r;
    // watch the entry pins through the quiet window after the high voltage arrives
    always_ff @(posedge mclk) begin
        if (!nrst || !hv_present) begin
            hv_prev_r <= 1'b0;
            watch_r <= 1'b0;
            mode_r <= 1'b0;
            fail_r <= 1'b0;
            quiet_cnt_r <= '0;
        end else begin
            hv_prev_r <= 1'b1;
            if (hv_rise) begin
                watch_r <= (entry_pins == `ENTRY_PINS_IDLE);
                fail_r <= (entry_pins != `ENTRY_PINS_IDLE);
                quiet_cnt_r <= 4'(`ENTRY_QUIET_CYC);
            end else if (watch_r) begin
                if (entry_pins != `ENTRY_PINS_IDLE) begin
                    watch_r <= 1'b0;
                    fail_r <= 1'b1;
                end else if (quiet_cnt_r == 4'h1) begin
                    watch_r <= 1'b0;
                    mode_r <= 1'b1;
                end else begin
                    quiet_cnt_r <= quiet_cnt_r - 4'h1;
                end
            end
        end
    end
    // a refused entry holds off the mode until the voltage is removed
    AST_ENTRY_REFUSE: assert property (@(posedge mclk) disable iff (!nrst)
        watch_r && entry_pins != `ENTRY_PINS_IDLE |=> fail_r && !prog_mode)
        else $error("entry accepted despite pin activity");
    AST_ENTRY_TIME: assert property (@(posedge mclk) disable iff (!nrst)
        hv_rise && entry_pins == `ENTRY_PINS_IDLE ##1 (hv_present &&
        entry_pins == `ENTRY_PINS_IDLE) [*4] |=> prog_mode)
        else $error("mode not entered after quiet window");
endmodule : prog_entry

// File: hdl/parallel_program_port.sv
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module parallel_program_port (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // high voltage detect and live fuse
    input wire logic hv_present,
    input wire logic eeprom_keep_fuse,
    // programmer strobes and selects
    input wire ppp_pkg::ctl_pins_type pins,
    // data bus, split into its three signals
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // handshake and mode
    output logic prog_ready,
    output logic prog_mode,
    // request stream to the nonvolatile macro
    output logic nvm_req_valid,
    input wire logic nvm_req_ready,
    output ppp_pkg::nvm_req_type nvm_req,
    input wire logic nvm_done,
    // read path
    output ppp_pkg::rd_req_type rd_req,
    input wire logic [7:0] rd_data
);
    import ppp_pkg::*;

    // ****************************************************************
    // command decoding
    // ****************************************************************
    // operation started by a write pulse, none when the command has no write
    function automatic nvm_op_type wr_op(input logic [7:0] cmd, input logic [1:0] bsel);
        nvm_op_type op;
        op = OP_NONE;
        unique case (cmd)
            `CMD_ERASE: op = OP_ERASE_FLASH;
            `CMD_WR_FUSE: op = OP_WR_FUSE;
            `CMD_WR_LOCK: op = OP_WR_LOCK;
            `CMD_WR_FLASH: op = (bsel == `BSEL_LO) ? OP_PROG_FLASH : OP_NONE;
            `CMD_WR_EE: op = (bsel == `BSEL_LO) ? OP_PROG_EE : OP_NONE;
            default: op = OP_NONE;
        endcase
        return op;
    endfunction : wr_op

    // true for the four read commands
    function automatic logic is_read(input logic [7:0] cmd);
        return cmd == `CMD_RD_SIG || cmd == `CMD_RD_FUSE ||
            cmd == `CMD_RD_FLASH || cmd == `CMD_RD_EE;
    endfunction : is_read

    // ****************************************************************
    // signals
    // ****************************************************************
    logic load_prev_r;
    logic latch_prev_r;
    logic wr_prev_r;
    logic load_rise;
    logic latch_rise;
    logic wr_fall;
    logic [1:0] action;
    logic [1:0] bsel;
    logic [3:0] entry_pins;
    logic [7:0] cmd_r;
    logic [7:0] addr_lo_r;
    logic [7:0] addr_hi_r;
    logic [7:0] addr_ext_r;
    logic [7:0] data_lo_r;
    logic [7:0] data_hi_r;
    logic [7:0] data_out_r;
    logic [`FLASH_ADDR_W-1:0] flash_addr;
    logic [`FLASH_WORD_W-1:0] word_in_page_index;
    logic [`FLASH_ADDR_W-`FLASH_WORD_W-1:0] flash_page_index;
    logic [`EE_ADDR_W-1:0] eeprom_addr;
    logic [`EE_BYTE_W-1:0] ee_byte_index;
    logic [`EE_ADDR_W-`EE_BYTE_W-1:0] ee_page_index;
    logic page_cmd;
    logic nop_load;
    nvm_op_type start_op;
    state_type state_r;
    nvm_req_type req_r;
    logic req_in_ready;

    assign action = {pins.action_select_hi, pins.action_select_lo};
    assign bsel = {pins.byte_select_hi, pins.byte_select_lo};
    // entry pins, most significant first
    assign entry_pins = {pins.page_latch_strobe, action, pins.byte_select_lo};

    // ****************************************************************
    // programming mode entry
    // ****************************************************************
    prog_entry u_entry (
        .mclk(mclk),
        .nrst(nrst),
        .hv_present(hv_present),
        .entry_pins(entry_pins),
        .prog_mode(prog_mode)
    );

    // ****************************************************************
    // strobe edges
    // ****************************************************************
    // previous strobe levels; strobes count only inside programming mode
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            load_prev_r <= 1'b0;
            latch_prev_r <= 1'b0;
            wr_prev_r <= 1'b1;
        end else begin
            load_prev_r <= pins.load_strobe;
            latch_prev_r <= pins.page_latch_strobe;
            wr_prev_r <= pins.wr_n;
        end
    end
    assign load_rise = prog_mode && pins.load_strobe && !load_prev_r;
    assign latch_rise = prog_mode && pins.page_latch_strobe && !latch_prev_r;
    assign wr_fall = prog_mode && !pins.wr_n && wr_prev_r;

    // ****************************************************************
    // address arithmetic
    // ****************************************************************
    // word index from low bits, page from the rest; low byte top bits join the page
    assign flash_addr = {addr_hi_r[`FLASH_ADDR_W-9:0], addr_lo_r};
    assign word_in_page_index = flash_addr[`FLASH_WORD_W-1:0];
    assign flash_page_index = flash_addr[`FLASH_ADDR_W-1:`FLASH_WORD_W];
    assign eeprom_addr = {addr_hi_r[`EE_ADDR_W-9:0], addr_lo_r};
    assign ee_byte_index = eeprom_addr[`EE_BYTE_W-1:0];
    assign ee_page_index = eeprom_addr[`EE_ADDR_W-1:`EE_BYTE_W];
    assign page_cmd = (cmd_r == `CMD_WR_FLASH) || (cmd_r == `CMD_WR_EE);
    assign start_op = wr_op(cmd_r, bsel);
    assign nop_load = load_rise && action == `ACT_CMD && data_in == `CMD_NOP;

    // ****************************************************************
    // load registers
    // ****************************************************************
    // command and address bytes persist across operations; a command is
    // refused while busy so the running operation keeps its decode
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmd_r <= `CMD_NOP;
            addr_lo_r <= `RESET_BYTE;
            addr_hi_r <= `RESET_BYTE;
            addr_ext_r <= `RESET_BYTE;
            data_lo_r <= `RESET_BYTE;
            data_hi_r <= `RESET_BYTE;
        end else if (!prog_mode) begin
            cmd_r <= `CMD_NOP;
        end else if (load_rise) begin
            unique case (action)
                `ACT_ADDR: begin
                    unique case (bsel)
                        `BSEL_LO: addr_lo_r <= data_in;
                        `BSEL_HI: addr_hi_r <= data_in;
                        `BSEL_EXT: addr_ext_r <= data_in;
                        default: ; // reserved select, nothing loaded
                    endcase
                end
                `ACT_DATA: begin
                    if (pins.byte_select_lo) begin
                        data_hi_r <= data_in;
                    end else begin
                        data_lo_r <= data_in;
                    end
                end
                `ACT_CMD: begin
                    if (state_r == ST_IDLE) begin
                        cmd_r <= data_in;
                    end
                end
                `ACT_IDLE: ; // no action
            endcase
        end
    end

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    // one request at a time; erase walks flash, eeprom (skipped when eeprom_keep_fuse is set), then lock bits so the
    // lock is only released once the program memory is gone
    always_ff @(posedge mclk) begin
        if (!nrst || !prog_mode) begin
            state_r <= ST_IDLE;
            req_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (nop_load) begin
                        req_r <= '{op: OP_END, addr: '0, data: '0, bsel: bsel};
                        state_r <= ST_ISSUE;
                    end else if (latch_rise && pins.byte_select_lo && page_cmd) begin
                        req_r <= '{op: (cmd_r == `CMD_WR_EE) ? OP_LATCH_EE : OP_LATCH_FLASH,
                            addr: (cmd_r == `CMD_WR_EE) ? 16'(ee_byte_index) :
                            16'(word_in_page_index),
                            data: {data_hi_r, data_lo_r}, bsel: bsel};
                        state_r <= ST_ISSUE;
                    end else if (wr_fall && start_op != OP_NONE) begin
                        req_r <= '{op: start_op,
                            addr: (start_op == OP_PROG_EE) ? 16'(ee_page_index) :
                            16'(flash_page_index),
                            data: {data_hi_r, data_lo_r}, bsel: bsel};
                        state_r <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (req_in_ready) begin
                        if (req_r.op == OP_LATCH_FLASH || req_r.op == OP_LATCH_EE ||
                            req_r.op == OP_END) begin
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY: begin
                    if (nvm_done) begin
                        if (req_r.op == OP_ERASE_FLASH) begin
                            req_r.op <= eeprom_keep_fuse ? OP_ERASE_LOCK : OP_ERASE_EE;
                            state_r <= ST_ISSUE;
                        end else if (req_r.op == OP_ERASE_EE) begin
                            req_r.op <= OP_ERASE_LOCK;
                            state_r <= ST_ISSUE;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ready whenever the sequencer is idle, even while a latch or end request still waits in the buffer
    assign prog_ready = (state_r == ST_IDLE);

    // ****************************************************************
    // request buffer
    // ****************************************************************
    // a macro stall backs up here and holds the sequencer in its issue state
    req_fifo #(
        .WIDTH($bits(nvm_req_type)),
        .DEPTH(2)
    ) u_req_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(state_r == ST_ISSUE),
        .in_ready(req_in_ready),
        .in_data(req_r),
        .out_valid(nvm_req_valid),
        .out_ready(nvm_req_ready),
        .out_data(nvm_req)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    assign rd_req = '{cmd: cmd_r, addr: {addr_ext_r, addr_hi_r, addr_lo_r}, bsel: bsel};
    // read byte is registered, so it trails a select change by one cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            data_out_r <= `RESET_BYTE;
        end else if (!pins.oe_n && is_read(cmd_r)) begin
            data_out_r <= rd_data;
        end
    end
    assign data_out = data_out_r;
    assign data_oe_n = !(prog_mode && !pins.oe_n && is_read(cmd_r));

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_cmd_load;
        load_rise && action == `ACT_CMD && state_r == ST_IDLE;
    endsequence
    sequence s_wr_start;
        state_r == ST_IDLE && !nop_load && !latch_rise && wr_fall && start_op != OP_NONE;
    endsequence
    sequence s_latch;
        state_r == ST_IDLE && !nop_load && latch_rise && pins.byte_select_lo && page_cmd;
    endsequence
    sequence s_flash_erased;
        state_r == ST_BUSY && req_r.op == OP_ERASE_FLASH && nvm_done;
    endsequence

    AST_CMD_LOAD: assert property (s_cmd_load |=> cmd_r == $past(data_in))
        else $error("command byte not loaded");
    AST_IDLE_ACTION: assert property (load_rise && action == `ACT_IDLE |=>
        $stable(cmd_r) && $stable(addr_lo_r) && $stable(data_lo_r) && $stable(data_hi_r))
        else $error("idle action changed a register");
    AST_DATA_HI: assert property (load_rise && action == `ACT_DATA &&
        pins.byte_select_lo |=> data_hi_r == $past(data_in) && $stable(data_lo_r))
        else $error("data high byte not loaded");
    AST_ADDR_EXT: assert property (load_rise && action == `ACT_ADDR &&
        bsel == `BSEL_EXT |=> addr_ext_r == $past(data_in) && $stable(addr_hi_r))
        else $error("extended address byte not loaded");
    AST_ADDR_HI_KEEP: assert property (load_rise && action == `ACT_ADDR &&
        bsel == `BSEL_LO |=> $stable(addr_hi_r))
        else $error("address high byte lost");
    AST_WR_BUSY: assert property (s_wr_start |=> !prog_ready ##1 !prog_ready)
        else $error("ready not low after write pulse");
    AST_FLASH_PAGE: assert property (s_wr_start ##0 start_op == OP_PROG_FLASH |=>
        req_r.op == OP_PROG_FLASH && req_r.addr == 16'($past(flash_page_index)))
        else $error("flash page write with wrong page");
    AST_LATCH: assert property (s_latch |=> state_r == ST_ISSUE &&
        req_r.data == {data_hi_r, data_lo_r})
        else $error("page latch not forwarded");
    AST_EE_LATCH: assert property (s_latch ##0 cmd_r == `CMD_WR_EE |=>
        req_r.op == OP_LATCH_EE && req_r.addr == 16'($past(ee_byte_index)))
        else $error("eeprom latch with wrong byte index");
    AST_ERASE_ORDER: assert property (s_flash_erased |=> state_r == ST_ISSUE &&
        req_r.op == ($past(eeprom_keep_fuse) ? OP_ERASE_LOCK : OP_ERASE_EE))
        else $error("erase order broken");
    AST_NOP_END: assert property (state_r == ST_IDLE && nop_load |=>
        state_r == ST_ISSUE && req_r.op == OP_END && cmd_r == `CMD_NOP ##1 state_r != ST_BUSY)
        else $error("no-operation did not end page writing");
    AST_HOLD_CMD: assert property (state_r == ST_BUSY && nvm_done |=> $stable(cmd_r))
        else $error("command lost across operation");
    AST_BUS_DRIVE: assert property (!data_oe_n |-> !pins.oe_n && prog_mode)
        else $error("bus driven without output enable");
endmodule : parallel_program_port

// File: tb/nvm_model.sv
`timescale 1ns/1ps
// ****************************************************************
// behavioural nonvolatile macro
// ****************************************************************
module nvm_model (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // request stream
    input wire logic req_valid,
    output logic req_ready,
    input wire ppp_pkg::nvm_req_type req,
    output logic done,
    // read path
    input wire ppp_pkg::rd_req_type rd_req,
    output logic [7:0] rd_data
);
    import ppp_pkg::*;
    logic [2:0] busy_r;
    logic slow_r;
    // ready only every other cycle and never during a long op, so the fifo stalls
    assign req_ready = slow_r && (busy_r == 3'h0);
    assign rd_data = rd_req.addr[7:0] + 8'h5a;
    always_ff @(posedge mclk) begin
        slow_r <= nrst && !slow_r;
        done <= nrst && (busy_r == 3'h1);
        if (!nrst) busy_r <= 3'h0;
        else if (busy_r != 3'h0) busy_r <= busy_r - 3'h1;
        else if (req_valid && req_ready && req.op > OP_LATCH_EE && req.op != OP_END) busy_r <= 3'h6;
    end
endmodule : nvm_model

// File: tb/tb_parallel_program_port.sv
`timescale 1ns/1ps
module tb_parallel_program_port;
    import ppp_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic hv_present = 1'b0;
    logic eeprom_keep_fuse = 1'b0;
    ctl_pins_type pins = 8'h03; // strobes idle, wr_n and oe_n high
    logic [7:0] data_in = 8'h00;
    logic [7:0] data_out, rd_data;
    logic data_oe_n, prog_ready, prog_mode, nvm_req_valid, nvm_req_ready, nvm_done;
    nvm_req_type nvm_req, r;
    rd_req_type rd_req;
    nvm_req_type taken_q[$];
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] rd_cmds [4] = '{8'h08, 8'h04, 8'h02, 8'h03};
    parallel_program_port dut (.mclk(mclk), .nrst(nrst), .hv_present(hv_present),
        .eeprom_keep_fuse(eeprom_keep_fuse), .pins(pins), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .prog_ready(prog_ready),
        .prog_mode(prog_mode), .nvm_req_valid(nvm_req_valid), .nvm_req_ready(nvm_req_ready),
        .nvm_req(nvm_req), .nvm_done(nvm_done), .rd_req(rd_req), .rd_data(rd_data));
    nvm_model nvm (.mclk(mclk), .nrst(nrst), .req_valid(nvm_req_valid),
        .req_ready(nvm_req_ready), .req(nvm_req), .done(nvm_done), .rd_req(rd_req),
        .rd_data(rd_data));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // record taken requests; cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (nvm_req_valid && nvm_req_ready) taken_q.push_back(nvm_req);
        if (cyc == 4000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op_is(input nvm_op_type op, input logic [15:0] addr, input logic use_a);
        for (int i = 0; i < 200 && taken_q.size() == 0; i++) @(posedge mclk);
        r = (taken_q.size() > 0) ? taken_q.pop_front() : '0;
        chk({12'h0, r.op}, {12'h0, op});
        if (use_a) chk(r.addr, addr);
    endtask : op_is
    // ****************************************************************
    // programmer strobes
    // ****************************************************************
    task automatic ld(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
        @(posedge mclk);
        {pins.action_select_hi, pins.action_select_lo} <= act;
        {pins.byte_select_hi, pins.byte_select_lo} <= bs;
        data_in <= d;
        pins.load_strobe <= 1'b1;
        @(posedge mclk);
        pins.load_strobe <= 1'b0;
        @(posedge mclk);
    endtask : ld
    task automatic pulse(input logic lat);
        @(posedge mclk);
        if (lat) pins.page_latch_strobe <= 1'b1;
        else pins.wr_n <= 1'b0;
        @(posedge mclk);
        pins.page_latch_strobe <= 1'b0;
        pins.wr_n <= 1'b1;
        @(posedge mclk);
        if (!lat) chk(prog_ready, 1'b0);
        for (int i = 0; i < 300 && prog_ready !== 1'b1; i++) @(posedge mclk);
        chk(prog_ready, 1'b1);
    endtask : pulse
    // reset already released, strobe toggled, pins 0000 for 100 ns, then high voltage;
    // a spoiled attempt flips an entry pin inside the quiet window and drops the voltage
    task automatic enter_mode(input logic spoil);
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            pins.load_strobe <= !pins.load_strobe;
        end
        repeat (4) @(posedge mclk);
        hv_present <= 1'b1;
        @(posedge mclk);
        pins.byte_select_lo <= spoil;
        repeat (6) @(posedge mclk);
        chk(prog_mode, {15'h0, !spoil});
        hv_present <= !spoil;
        pins.byte_select_lo <= 1'b0;
    endtask : enter_mode
    task automatic final_report();
        $display("compared %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        enter_mode(1'b1);
        enter_mode(1'b0);
        repeat (2000) @(posedge mclk);
        // erase before any programming, with and without the eeprom keep fuse
        for (int k = 0; k < 2; k++) begin
            eeprom_keep_fuse <= k[0];
            ld(2'h2, 2'h0, 8'h80);
            pulse(1'b0);
            op_is(OP_ERASE_FLASH, 16'h0, 1'b0);
            if (k == 0) op_is(OP_ERASE_EE, 16'h0, 1'b0);
            op_is(OP_ERASE_LOCK, 16'h0, 1'b0);
        end
        ld(2'h2, 2'h0, 8'h10);
        ld(2'h0, 2'h1, 8'h02);
        // two pages, command and high byte loaded once
        for (int p = 0; p < 2; p++) begin
            ld(2'h0, 2'h0, p ? 8'h05 : 8'h85);
            ld(2'h1, 2'h0, 8'h34);
            ld(2'h1, 2'h1, 8'h12);
            pulse(1'b1);
            op_is(OP_LATCH_FLASH, 16'h0005, 1'b1);
            chk(r.data, 16'h1234);
            ld(2'h3, 2'h0, 8'hff);
            pulse(1'b0);
            op_is(OP_PROG_FLASH, p ? 16'h0004 : 16'h0005, 1'b1);
        end
        ld(2'h2, 2'h0, 8'h11);
        ld(2'h0, 2'h1, 8'h02);
        ld(2'h0, 2'h0, 8'h0d);
        ld(2'h1, 2'h1, 8'hab);
        pulse(1'b1);
        op_is(OP_LATCH_EE, 16'h0005, 1'b1);
        ld(2'h3, 2'h0, 8'h00);
        pulse(1'b0);
        op_is(OP_PROG_EE, 16'h0041, 1'b1);
        // fuse and lock writes each queue one long operation
        for (int k = 0; k < 2; k++) begin
            ld(2'h2, 2'h0, k ? 8'h20 : 8'h40);
            pulse(1'b0);
            op_is(k ? OP_WR_LOCK : OP_WR_FUSE, 16'h0, 1'b0);
        end
        ld(2'h2, 2'h0, 8'h00);
        op_is(OP_END, 16'h0, 1'b0);
        // every read command turns the bus around
        foreach (rd_cmds[k]) begin
            ld(2'h2, 2'h0, rd_cmds[k]);
            pins.oe_n <= 1'b0;
            repeat (3) @(posedge mclk);
            chk(data_oe_n, 1'b0);
            chk(data_out, 8'h67);
            chk(rd_req.cmd, rd_cmds[k]);
            pins.oe_n <= 1'b1;
            repeat (2) @(posedge mclk);
            chk(data_oe_n, 1'b1);
        end
        final_report();
    end
endmodule : tb_parallel_program_port
